// ==== design/scs_atr_timer.sv ====
// answer-to-reset timer counting card clock pulses for asynchronous cards
`timescale 1ns/1ns
`include "scs_map.svh"
module scs_atr_timer
	import scs_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// control from the sequencer
	input  wire logic        run,
	input  wire logic        ck_rise,
	input  wire logic        io_fall,
	input  wire logic [15:0] cnt_l,
	input  wire logic [7:0]  early_l,
	// results
	output logic             rst_high,
	output logic             done,
	output logic             ev_early,
	output logic             ev_mute
);

	scs_atr_t r;
	scs_atr_t r_nxt;
	logic [16:0] early_lim;

	// early window end: ignore span plus programmed window
	assign early_lim = {1'b0, `SCS_ATR_IGNORE} + {9'h000, early_l};

	// pulse counting and window checks; a start bit wins over expiry in the same cycle
	always_comb begin
		r_nxt          = r;
		r_nxt.ev_early = 1'b0;
		r_nxt.ev_mute  = 1'b0;
		if (!run) begin
			r_nxt = '0;
		end else if (!r.done) begin
			if (!r.phase) begin
				if (io_fall && r.cnt >= `SCS_ATR_IGNORE) begin
					r_nxt.ev_early = 1'b1;
					r_nxt.ev_mute  = 1'b1;
					r_nxt.done     = 1'b1;
					r_nxt.bad      = 1'b1;
				end else if (r.cnt >= cnt_l) begin
					r_nxt.phase = 1'b1;
					r_nxt.cnt   = '0;
				end else if (ck_rise) begin
					r_nxt.cnt = r.cnt + 16'h0001;
				end
			end else begin
				if (io_fall) begin
					r_nxt.ev_early = ({1'b0, r.cnt} < early_lim);
					r_nxt.bad      = ({1'b0, r.cnt} < early_lim);
					r_nxt.done     = 1'b1;
				end else if (r.cnt >= `SCS_ATR_MUTE) begin
					r_nxt.ev_mute = 1'b1;
					r_nxt.done    = 1'b1;
					r_nxt.bad     = 1'b1;
				end else if (ck_rise) begin
					r_nxt.cnt = r.cnt + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign rst_high = r.phase;
	assign done     = r.done && !r.bad; // answer accepted, stays after flags are read
	assign ev_early = r.ev_early;
	assign ev_mute  = r.ev_mute;

endmodule : scs_atr_timer

// ==== design/scs_map.svh ====
// register map, field positions, reset values and timing counts of the card session sequencer
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

// register indices on the host register port
`define SCS_A_CMD       3'h0
`define SCS_A_MODE      3'h1
`define SCS_A_EARLY     3'h2
`define SCS_A_CNTH      3'h3
`define SCS_A_CNTL      3'h4
`define SCS_A_STAT      3'h5

// field positions
`define SCS_CMD_START   0
`define SCS_CMD_SYNC_CLK_SEL 3
`define SCS_MODE_RST_LEVEL   6
`define SCS_MODE_CLK_LEVEL   2

// reset values
`define SCS_RST_CNTH    8'hA4
`define SCS_RST_CNTL    8'h74
`define SCS_RST_EARLY   8'hAA

// step unit T and its sixty-fourth in system clock cycles
`define SCS_T_NS        25000
`define SCS_CLK_NS      20
`define SCS_SUB_CYC     ((`SCS_T_NS / 64) / `SCS_CLK_NS)

// activation milestones in T/64 units from the request
`define SCS_ACT_CONV    9'h001
`define SCS_ACT_VCC     9'h061
`define SCS_ACT_IO      9'h0E1
`define SCS_ACT_CLK     9'h101

// deactivation milestones in T/64 units from the start clear
`define SCS_DEA_RST     9'h001
`define SCS_DEA_CLK     9'h021
`define SCS_DEA_IO      9'h041
`define SCS_DEA_VCC     9'h061
`define SCS_DEA_END     9'h0E1

// answer-to-reset windows in card clock pulses
`define SCS_ATR_IGNORE  16'h00C8
`define SCS_ATR_MUTE    16'hA474

`endif

// ==== design/scs_pkg.sv ====
// types shared by the card session sequencer modules
package scs_pkg;

	typedef enum logic [1:0] {SCS_IDLE, SCS_ACT, SCS_ATR, SCS_DEACT} scs_state_t;

	// fault pins of the analog front end, all active high
	typedef struct packed {
		logic ovc_vcc;
		logic ovc_clk;
		logic ovc_io;
		logic ovc_rst;
		logic overheat;
		logic vdd_drop;
		logic dcdc_fault;
	} scs_fault_t;

	// answer-to-reset timer state
	typedef struct packed {
		logic        phase;
		logic        done;
		logic        bad;
		logic [15:0] cnt;
		logic        ev_early;
		logic        ev_mute;
	} scs_atr_t;

	// sequencer state
	typedef struct packed {
		scs_state_t  st;
		logic [4:0]  sub;
		logic [8:0]  step;
		logic        start;
		logic        sync_clock_level_select;
		logic        card_reset_level_bit;
		logic        static_clock_level_bit;
		logic [7:0]  cnth;
		logic [7:0]  cntl;
		logic [7:0]  early;
		logic        async_l;
		logic        sync_clock_level_select_l;
		logic [15:0] cnt_l;
		logic [7:0]  early_l;
		logic        f_early;
		logic        f_mute;
		logic        contact_overload_flag;
		logic        alert;
		logic        alert_n;
		logic        osc_fast;
		logic        conv_en;
		logic        vcc_en;
		logic        io_rel;
		logic        io_oe;
		logic        clk_en;
		logic        card_clk;
		logic        card_rst;
		logic        gnd_tie;
		logic        link_free;
		logic        ck_prev;
		logic        io_prev;
		logic [7:0]  rdata;
	} scs_ctl_t;

endpackage : scs_pkg

// ==== design/scs_sequencer.sv ====
// card session sequencer: contact power order, card reset and clock, answer timing, emergency shutdown
`timescale 1ns/1ns
`include "scs_map.svh"
module scs_sequencer
	import scs_pkg::*;
(
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RST,
	// host register port
	input  wire logic [2:0] REG_ADDR,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire logic [7:0] REG_WDATA,
	output logic      [7:0] REG_RDATA,
	output logic            HOST_ALERT_N,
	// supervision pins
	input  wire logic       CARD_DETECT,
	input  wire logic       SUPPLY_ALARM,
	input  wire scs_fault_t FAULTS,
	// clock source pin
	input  wire logic       SOURCE_CLOCK_INPUT,
	// card contacts
	input  wire logic       CARD_IO_IN,
	output logic            CARD_IO_OUT,
	output logic            CARD_IO_OE,
	output logic            CARD_CLK,
	output logic            CARD_RST,
	output logic            CARD_VCC_EN,
	output logic            CARD_GND_TIE,
	// analog controls and session status
	output logic            DCDC_EN,
	output logic            OSC_FAST,
	output logic            LINK_FREE
);

	localparam int SYNC_W = 11;
	localparam logic [4:0] SUB_LAST = 5'(`SCS_SUB_CYC - 1);

	scs_ctl_t          r;
	scs_ctl_t          r_nxt;
	logic [SYNC_W-1:0] pin_s;
	scs_fault_t        flt_s;
	logic              source_s;
	logic              io_s;
	logic              detect_s;
	logic              alarm_s;
	logic              tick;
	logic              ck_rise;
	logic              io_fall;
	logic              atr_run;
	logic              atr_rst_high;
	logic              atr_done;
	logic              atr_early;
	logic              atr_mute;
	logic              contact_ovl;
	logic              emergency;
	logic              in_session;
	logic              src_clk;

	// every pin input is synchronised before use
	scs_sync #(
		.W (SYNC_W)
	) u_sync (
		.clk (CLK),
		.rst (RST),
		.d   ({SOURCE_CLOCK_INPUT, CARD_IO_IN, CARD_DETECT, SUPPLY_ALARM, FAULTS}),
		.q   (pin_s)
	);

	assign source_s = pin_s[10];
	assign io_s     = pin_s[9];
	assign detect_s = pin_s[8];
	assign alarm_s  = pin_s[7];
	assign flt_s   = pin_s[6:0];

	// edge detection on synchronised card clock and data line
	assign tick    = (r.sub == SUB_LAST);
	assign ck_rise = source_s && !r.ck_prev;
	assign io_fall = r.io_rel && r.io_prev && !io_s;
	assign atr_run = (r.st == SCS_ATR) && r.async_l;

	// clock for the card: undivided source unless the static level is selected in a synchronous session
	assign src_clk = (r.async_l || !r.sync_clock_level_select_l) ? source_s : r.static_clock_level_bit;

	// fault classification
	assign contact_ovl = flt_s.ovc_clk || flt_s.ovc_io || flt_s.ovc_rst || flt_s.ovc_vcc;
	assign in_session  = (r.st == SCS_ACT) || (r.st == SCS_ATR);
	assign emergency   = in_session && (contact_ovl || flt_s.overheat || flt_s.vdd_drop
	                     || flt_s.dcdc_fault || alarm_s || !detect_s);

	scs_atr_timer u_atr (
		.clk      (CLK),
		.rst      (RST),
		.run      (atr_run),
		.ck_rise  (ck_rise),
		.io_fall  (io_fall),
		.cnt_l    (r.cnt_l),
		.early_l  (r.early_l),
		.rst_high (atr_rst_high),
		.done     (atr_done),
		.ev_early (atr_early),
		.ev_mute  (atr_mute)
	);

	// next state of the whole sequencer
	always_comb begin
		r_nxt         = r;
		r_nxt.sub     = tick ? 5'h00 : r.sub + 5'h01;
		r_nxt.ck_prev = source_s;
		r_nxt.io_prev = io_s;

		// status read returns a snapshot and clears the sticky flags
		if (REG_RD) begin
			case (REG_ADDR)
				`SCS_A_CMD:   r_nxt.rdata = {4'h0, r.sync_clock_level_select, 2'b00, r.start};
				`SCS_A_MODE:  r_nxt.rdata = {1'b0, r.card_reset_level_bit, 3'b000, r.static_clock_level_bit, 2'b00};
				`SCS_A_EARLY: r_nxt.rdata = r.early;
				`SCS_A_CNTH:  r_nxt.rdata = r.cnth;
				`SCS_A_CNTL:  r_nxt.rdata = r.cntl;
				`SCS_A_STAT: begin
					r_nxt.rdata   = {1'b0, r.link_free, in_session, detect_s, alarm_s,
					                 r.contact_overload_flag, r.f_mute, r.f_early};
					r_nxt.f_early = 1'b0;
					r_nxt.f_mute  = 1'b0;
					r_nxt.contact_overload_flag = 1'b0;
					r_nxt.alert   = 1'b0;
				end
				default:      r_nxt.rdata = 8'h00;
			endcase
		end

		// register writes
		if (REG_WR) begin
			case (REG_ADDR)
				`SCS_A_CMD: begin
					if (!r.start) begin
						r_nxt.sync_clock_level_select = REG_WDATA[`SCS_CMD_SYNC_CLK_SEL];
					end
					if (REG_WDATA[`SCS_CMD_START] && !r.start && r.st == SCS_IDLE
					    && detect_s && !alarm_s) begin
						r_nxt.start    = 1'b1;
						r_nxt.st       = SCS_ACT;
						r_nxt.step     = 9'h000;
						r_nxt.sub      = 5'h00;
						r_nxt.async_l  = r.card_reset_level_bit;
						// select bit written with the start bit counts for this session
						r_nxt.sync_clock_level_select_l = REG_WDATA[`SCS_CMD_SYNC_CLK_SEL];
						r_nxt.cnt_l    = {r.cnth, r.cntl};
						r_nxt.early_l  = r.early;
						r_nxt.f_early  = 1'b0;
						r_nxt.f_mute   = 1'b0;
						r_nxt.osc_fast = 1'b1;
						r_nxt.gnd_tie  = 1'b0;
					end else if (!REG_WDATA[`SCS_CMD_START] && r.start) begin
						r_nxt.start = 1'b0;
					end
				end
				`SCS_A_MODE: begin
					r_nxt.card_reset_level_bit   = REG_WDATA[`SCS_MODE_RST_LEVEL];
					r_nxt.static_clock_level_bit = REG_WDATA[`SCS_MODE_CLK_LEVEL];
				end
				`SCS_A_EARLY: r_nxt.early = REG_WDATA;
				`SCS_A_CNTH:  r_nxt.cnth  = REG_WDATA;
				`SCS_A_CNTL:  r_nxt.cntl  = REG_WDATA;
				default: ;
			endcase
		end

		// sequence control
		case (r.st)
			SCS_IDLE: begin
				r_nxt.conv_en   = 1'b0;
				r_nxt.vcc_en    = 1'b0;
				r_nxt.io_rel    = 1'b0;
				r_nxt.clk_en    = 1'b0;
				r_nxt.card_clk  = 1'b0;
				r_nxt.card_rst  = 1'b0;
				r_nxt.link_free = 1'b0;
			end
			SCS_ACT: begin
				if (tick) begin
					r_nxt.step = r.step + 9'h001;
				end
				r_nxt.conv_en = (r.step >= `SCS_ACT_CONV);
				r_nxt.vcc_en  = (r.step >= `SCS_ACT_VCC);
				r_nxt.io_rel  = (r.step >= `SCS_ACT_IO);
				if (r.step >= `SCS_ACT_CLK) begin
					r_nxt.clk_en = 1'b1;
					r_nxt.st     = SCS_ATR;
				end
			end
			SCS_ATR: begin
				r_nxt.card_clk = src_clk;
				if (r.async_l) begin
					r_nxt.card_rst  = atr_rst_high;
					r_nxt.link_free = atr_done;
				end else begin
					r_nxt.card_rst  = r.card_reset_level_bit;
					r_nxt.link_free = 1'b1;
				end
			end
			SCS_DEACT: begin
				if (tick) begin
					r_nxt.step = r.step + 9'h001;
				end
				r_nxt.link_free = 1'b0;
				if (r.step >= `SCS_DEA_RST) begin
					r_nxt.card_rst = 1'b0;
				end
				if (r.step >= `SCS_DEA_CLK) begin
					r_nxt.clk_en   = 1'b0;
					r_nxt.card_clk = 1'b0;
				end else if (r.clk_en) begin
					r_nxt.card_clk = src_clk;
				end
				if (r.step >= `SCS_DEA_IO) begin
					r_nxt.io_rel = 1'b0;
				end
				if (r.step >= `SCS_DEA_VCC) begin
					r_nxt.vcc_en = 1'b0;
				end
				if (r.step >= `SCS_DEA_END) begin
					r_nxt.conv_en  = 1'b0;
					r_nxt.osc_fast = 1'b0;
					r_nxt.gnd_tie  = 1'b1;
					r_nxt.st       = SCS_IDLE;
				end
			end
			default: r_nxt.st = SCS_IDLE;
		endcase

		// host ends the session
		if (in_session && !r.start) begin
			r_nxt.st   = SCS_DEACT;
			r_nxt.step = 9'h000;
			r_nxt.sub  = 5'h00;
		end

		// hardware faults take over, flags set after any clear so the set wins
		if (emergency) begin
			r_nxt.st    = SCS_DEACT;
			r_nxt.step  = 9'h000;
			r_nxt.sub   = 5'h00;
			r_nxt.start = 1'b0;
			r_nxt.alert = 1'b1;
		end
		if (emergency && contact_ovl) begin
			r_nxt.contact_overload_flag = 1'b1;
		end
		if (atr_early) begin
			r_nxt.f_early = 1'b1;
		end
		if (atr_mute) begin
			r_nxt.f_mute = 1'b1;
		end

		// active-low copies kept in flip-flops so the pins need no gate
		r_nxt.alert_n = !r_nxt.alert;
		r_nxt.io_oe   = !r_nxt.io_rel;
	end

	// register the state; reset gives the documented defaults
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			r         <= '0;
			r.st      <= SCS_IDLE;
			r.cnth    <= `SCS_RST_CNTH;
			r.cntl    <= `SCS_RST_CNTL;
			r.early   <= `SCS_RST_EARLY;
			r.gnd_tie <= 1'b1;
			r.alert_n <= 1'b1;
			r.io_oe   <= 1'b1;
		end else begin
			r <= r_nxt;
		end
	end

	// outputs straight from the state register, except the data output tied low
	assign REG_RDATA    = r.rdata;
	assign HOST_ALERT_N = r.alert_n;
	assign CARD_IO_OUT  = 1'b0;
	assign CARD_IO_OE   = r.io_oe; // low drive until released to the pull-up
	assign CARD_CLK     = r.card_clk;
	assign CARD_RST     = r.card_rst;
	assign CARD_VCC_EN  = r.vcc_en;
	assign CARD_GND_TIE = r.gnd_tie;
	assign DCDC_EN      = r.conv_en;
	assign OSC_FAST     = r.osc_fast;
	assign LINK_FREE    = r.link_free;

endmodule : scs_sequencer

// ==== design/scs_sync.sv ====
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module scs_sync
	import scs_pkg::*;
#(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// pins and their synchronised copies
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] held;
	} scs_sync_t;

	scs_sync_t r;
	scs_sync_t r_nxt;

	// first stage feeds only the second stage
	always_comb begin
		r_nxt      = r;
		r_nxt.meta = d;
		r_nxt.held = r.meta;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign q = r.held;

endmodule : scs_sync

// ==== dv/scs_card_model.sv ====
// behavioural smart card that counts clock pulses and sends one start bit
`timescale 1ns/1ns
module scs_card_model (
	// card contacts
	input  wire logic   card_clk,
	input  wire logic   vcc_en,
	input  wire logic   io_oe,
	output logic        io_level,
	// answer point and pulses seen since power-up
	input  wire integer ans_at,
	output int          pulses
);
	// pulse count restarts with every power-up
	always @(posedge card_clk or negedge vcc_en) begin
		if (!vcc_en)
			pulses <= 0;
		else
			pulses <= pulses + 1;
	end
	// start bit lasts twelve pulses; released line sits at the pull-up, unpowered line at ground
	assign io_level = vcc_en && !io_oe && !(pulses >= ans_at && pulses < ans_at + 12);
endmodule : scs_card_model

// ==== dv/scs_sequencer_chk.sv ====
// checker of contact ordering, step timing and alert behaviour
`timescale 1ns/1ns
module scs_sequencer_chk
	import scs_pkg::*;
(
	// clock, reset and supervision
	input wire logic       CLK,
	input wire logic       RST,
	input wire logic       CARD_DETECT,
	input wire logic       SUPPLY_ALARM,
	input wire scs_fault_t FAULTS,
	// contacts and status
	input wire logic       HOST_ALERT_N,
	input wire logic       CARD_IO_OE,
	input wire logic       CARD_CLK,
	input wire logic       CARD_RST,
	input wire logic       CARD_VCC_EN,
	input wire logic       CARD_GND_TIE,
	input wire logic       DCDC_EN,
	input wire logic       OSC_FAST,
	input wire logic       LINK_FREE
);
	logic [15:0] conv_r;
	logic [15:0] off_r;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// cycles since converter start and since supply fell
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			conv_r <= 16'h0000;
			off_r  <= 16'h0000;
		end else begin
			conv_r <= DCDC_EN ? conv_r + 16'h0001 : 16'h0000;
			off_r  <= CARD_VCC_EN ? 16'h0000 : off_r + 16'h0001;
		end
	end
	chk_idle_ground: assert property (!OSC_FAST |-> CARD_GND_TIE && CARD_IO_OE && !CARD_VCC_EN
		&& !CARD_CLK && !CARD_RST && !DCDC_EN) else $error("idle contacts not grounded");
	chk_start_gate: assert property ($rose(OSC_FAST) |-> $past(CARD_DETECT, 3) && !$past(SUPPLY_ALARM, 3))
		else $error("activation without card or with alarm");
	chk_conv_start: assert property ($rose(OSC_FAST) |-> !DCDC_EN[*8] ##[1:16] $rose(DCDC_EN))
		else $error("converter start late");
	chk_act_order: assert property ($rose(CARD_VCC_EN) |-> DCDC_EN && OSC_FAST && CARD_IO_OE && !CARD_CLK)
		else $error("activation order broken");
	chk_vcc_ramp: assert property ($rose(CARD_VCC_EN) |-> conv_r inside {[16'h071A:16'h0726]})
		else $error("supply ramp step wrong");
	chk_io_release: assert property ($fell(CARD_IO_OE) |-> conv_r inside {[16'h109A:16'h10A6]})
		else $error("data release step wrong");
	chk_deact_order: assert property ($fell(CARD_VCC_EN) |-> !CARD_CLK && !CARD_RST && CARD_IO_OE)
		else $error("deactivation order broken");
	chk_deact_end: assert property ($fell(DCDC_EN) |-> off_r inside {[16'h097A:16'h0986]} && !OSC_FAST)
		else $error("converter stop step wrong");
	chk_alert_ovc: assert property ($rose(FAULTS.ovc_clk) && DCDC_EN |-> ##[1:8] !HOST_ALERT_N)
		else $error("overload alert missing");
	chk_link_live: assert property (LINK_FREE |-> DCDC_EN && !CARD_GND_TIE)
		else $error("link free outside session");
	// main scenarios reached
	cov_link: cover property ($rose(LINK_FREE));
	cov_alert: cover property ($fell(HOST_ALERT_N));
	cov_rst_high: cover property ($rose(CARD_RST));
endmodule : scs_sequencer_chk

bind scs_sequencer scs_sequencer_chk u_chk (.CLK(CLK), .RST(RST), .CARD_DETECT(CARD_DETECT),
	.SUPPLY_ALARM(SUPPLY_ALARM), .FAULTS(FAULTS), .HOST_ALERT_N(HOST_ALERT_N), .CARD_IO_OE(CARD_IO_OE),
	.CARD_CLK(CARD_CLK), .CARD_RST(CARD_RST), .CARD_VCC_EN(CARD_VCC_EN), .CARD_GND_TIE(CARD_GND_TIE),
	.DCDC_EN(DCDC_EN), .OSC_FAST(OSC_FAST), .LINK_FREE(LINK_FREE));

// ==== dv/smart_card_session_sequencer_bench.sv ====
// self-checking bench of the card session sequencer with a card model
`timescale 1ns/1ns
`include "scs_map.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
`define WAITS(c) begin int k; k = 0; while (!(c) && k < 20000) begin @(negedge clk); k++; end \
	`CHK((c), 1'b1) end
module smart_card_session_sequencer_bench
	import scs_pkg::*;
;
	logic       clk, rst, reg_wr, reg_rd, card_detect, supply_alarm, src, io_in, b;
	logic       alert_n, io_oe, card_clk, card_rst, vcc_en, gnd_tie, dcdc_en, osc_fast, link_free;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, d;
	logic [7:0] mdl [8];
	logic [31:0] seed;
	scs_fault_t faults;
	int         miscompares, cmp_count, ans_at, pulses, r;
	int         ans_tab [4] = '{100, 250, 400, 800};
	logic [7:0] stat_tab [4] = '{8'h30, 8'h33, 8'h31, 8'h70};
	logic [3:0] rst_tab = 4'b1101;

	scs_sequencer u_dut (.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .HOST_ALERT_N(alert_n), .CARD_DETECT(card_detect),
		.SUPPLY_ALARM(supply_alarm), .FAULTS(faults), .SOURCE_CLOCK_INPUT(src), .CARD_IO_IN(io_in),
		.CARD_IO_OUT(), .CARD_IO_OE(io_oe), .CARD_CLK(card_clk), .CARD_RST(card_rst), .CARD_VCC_EN(vcc_en),
		.CARD_GND_TIE(gnd_tie), .DCDC_EN(dcdc_en), .OSC_FAST(osc_fast), .LINK_FREE(link_free));
	scs_card_model u_card (.card_clk(card_clk), .vcc_en(vcc_en), .io_oe(io_oe), .io_level(io_in),
		.ans_at(ans_at), .pulses(pulses));

	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// register write, mirrored into the model for the early and count registers
	task wr(input logic [2:0] a, input logic [7:0] v);
		@(negedge clk); addr = a; wdata = v; reg_wr = 1'b1;
		@(negedge clk); reg_wr = 1'b0;
		if (a inside {3'h2, 3'h3, 3'h4}) mdl[a] = v;
	endtask : wr
	task rd(input logic [2:0] a);
		@(negedge clk); addr = a; reg_rd = 1'b1;
		@(negedge clk); reg_rd = 1'b0;
		@(negedge clk); d = rdata;
	endtask : rd
	task deact();
		wr(`SCS_A_CMD, 8'h00);
		`WAITS(gnd_tie === 1'b1)
		`CHK({dcdc_en, osc_fast, vcc_en, card_clk, card_rst, io_oe}, 6'h01)
	endtask : deact
	// emergency shutdown by a fault or card removal; status read then clears the alert
	task emerg(input scs_fault_t f, input logic det, input logic [7:0] st);
		faults = f;
		card_detect = det;
		`WAITS(gnd_tie === 1'b1)
		`CHK({alert_n, dcdc_en, vcc_en}, 3'h0)
		faults = '0;
		card_detect = 1'b1;
		rd(`SCS_A_CMD); `CHK(d[0], 1'b0)
		rd(`SCS_A_STAT); `CHK(d & 8'h24, st)
		`CHK(alert_n, 1'b1)
	endtask : emerg
	task finish_test();
		$display("mismatches %0d comparisons %0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	// system clock and free-running card clock source
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		src = 1'b0;
		forever begin
			repeat (3) @(negedge clk);
			src = ~src;
		end
	end
	// watchdog against a hang
	initial begin
		#2000000;
		miscompares++;
		finish_test();
	end
	// main sequence
	initial begin
		rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; addr = 3'h0; wdata = 8'h00; faults = '0;
		card_detect = 1'b0; supply_alarm = 1'b0; ans_at = 1000000; seed = 32'hB8D7655E;
		mdl = '{default: 8'h00}; mdl[2] = `SCS_RST_EARLY; mdl[3] = `SCS_RST_CNTH; mdl[4] = `SCS_RST_CNTL;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		for (int a = 2; a < 8; a++) begin
			rd(a[2:0]);
			`CHK(d, mdl[a])
		end
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wr(`SCS_A_CNTH, seed[7:0]); wr(`SCS_A_CNTL, seed[15:8]);
			rd(`SCS_A_CNTH); `CHK(d, mdl[3])
			rd(`SCS_A_CNTL); `CHK(d, mdl[4])
		end
		// start refused with no card, then with the supply alarm up
		for (int i = 0; i < 2; i++) begin
			card_detect = i[0]; supply_alarm = i[0];
			repeat (4) @(negedge clk);
			wr(`SCS_A_CMD, 8'h01);
			repeat (4) @(negedge clk);
			rd(`SCS_A_CMD);
			`CHK({d[0], dcdc_en, osc_fast}, 3'h0)
		end
		supply_alarm = 1'b0;
		// asynchronous sessions with count 300, rewritten mid-session
		for (int i = 0; i < 4; i++) begin
			wr(`SCS_A_CNTH, 8'h01); wr(`SCS_A_CNTL, 8'h2C); wr(`SCS_A_MODE, 8'h40);
			ans_at = ans_tab[i];
			wr(`SCS_A_CMD, 8'h01); wr(`SCS_A_CNTH, 8'h10);
			`WAITS(pulses >= 900)
			`CHK(card_rst, rst_tab[i])
			rd(`SCS_A_STAT); `CHK(d, stat_tab[i])
			`CHK(link_free, stat_tab[i][6])
			// host ends the first two, card removal and clock overload the last two
			if (i < 2)
				deact();
			else
				emerg(i == 3 ? 7'h20 : 7'h00, i == 3, i == 3 ? 8'h04 : 8'h00);
		end
		// synchronous sessions: clock passed through, then held from the level bit
		ans_at = 1000000;
		for (int j = 0; j < 2; j++) begin
			wr(`SCS_A_MODE, j ? 8'h04 : 8'h00); wr(`SCS_A_CMD, j ? 8'h09 : 8'h01);
			`WAITS(link_free === 1'b1)
			r = 0;
			for (int k = 0; k < 60; k++) begin
				b = card_clk;
				@(negedge clk);
				if (card_clk === 1'b1 && b === 1'b0) r++;
			end
			`CHK(j ? (r == 0 && card_clk === 1'b1) : (r >= 9), 1'b1)
			`CHK(card_rst, 1'b0)
			if (j)
				emerg(7'h40, 1'b1, 8'h04);
			else
				deact();
		end
		finish_test();
	end
endmodule : smart_card_session_sequencer_bench
